// ### inc/fpx_pkg.sv
package fpx_pkg;
  // Exception kinds from the sequencer
  localparam logic [1:0] KIND_OVERFLOW_EXCEPTION = 2'h0;
  localparam logic [1:0] KIND_UNDERFLOW_EXCEPTION = 2'h1;
  localparam logic [1:0] KIND_DZ = 2'h2;
  // Operation codes from the sequencer
  localparam logic [3:0] OP_MOVE_REG = 4'h0;
  localparam logic [3:0] OP_MOVE_MEM = 4'h1;
  localparam logic [3:0] OP_ABS = 4'h2;
  localparam logic [3:0] OP_NEG = 4'h3;
  localparam logic [3:0] OP_ADD = 4'h4;
  localparam logic [3:0] OP_SUB = 4'h5;
  localparam logic [3:0] OP_MUL = 4'h6;
  localparam logic [3:0] OP_DIV = 4'h7;
  localparam logic [3:0] OP_SQRT = 4'h8;
  // Operand formats
  localparam logic [1:0] FMT_SINGLE = 2'h0;
  localparam logic [1:0] FMT_DOUBLE = 2'h1;
  localparam logic [1:0] FMT_EXT = 2'h2;
  // Exponent biases and limits
  localparam logic [14:0] SGL_BIAS = 15'h007F;
  localparam logic [14:0] DBL_BIAS = 15'h03FF;
  localparam logic [14:0] EXT_BIAS = 15'h3FFF;
  localparam logic [14:0] EXT_EXP_MAX = 15'h7FFF;
  localparam logic [14:0] SGL_DENORM_EXP = 15'h0001;
  localparam logic [14:0] DBL_DENORM_EXP = 15'h0001;
  // Source tag code for a normalized operand
  localparam logic [2:0] TAG_NORM = 3'h0;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RELEASE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0C;
  localparam logic [7:0] REG_INFO = 8'h10;
  localparam logic [7:0] REG_CMD = 8'h14;
  localparam logic [7:0] REG_SRC_LO = 8'h20;
  localparam logic [7:0] REG_SRC_HI = 8'h24;
  localparam logic [7:0] REG_SRC_SE = 8'h28;
  localparam logic [7:0] REG_DST_LO = 8'h30;
  localparam logic [7:0] REG_DST_HI = 8'h34;
  localparam logic [7:0] REG_DST_SE = 8'h38;
  localparam logic [7:0] REG_WB_LO = 8'h40;
  localparam logic [7:0] REG_WB_HI = 8'h44;
  localparam logic [7:0] REG_WB_SE = 8'h48;
  // Status and mask bit positions
  localparam int ST_OVERFLOW_EXCEPTION = 0;
  localparam int ST_UNDERFLOW_EXCEPTION = 1;
  localparam int ST_DZ = 2;
  localparam int ST_W = 3;
  // Control and info bit positions
  localparam int CTRL_EN = 0;
  localparam int INFO_E1 = 0;
  localparam int INFO_E3 = 1;
  localparam int INFO_T = 2;
  localparam int INFO_TAG = 4;
  localparam int INFO_STICKY = 8;
  localparam int INFO_ROUND = 9;
  localparam int INFO_GUARD = 10;
  localparam int INFO_LOCK = 16;
  localparam int CMD3_POS = 16;
  // Reset value of the control register: capture enabled
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### inc/fpx_conv_if.sv
`timescale 1ns/1ns
interface fpx_conv_if;
  logic [1:0] fmt;
  logic [79:0] bits;
  logic sign;
  logic [14:0] exp;
  logic [63:0] mant;
  modport owner (output fmt, output bits, input sign, input exp, input mant);
  modport conv (input fmt, input bits, output sign, output exp, output mant);
endinterface

// ### rtl/fpx_convert.sv
`timescale 1ns/1ns
module fpx_convert (
  // Operand in, extended precision out
  fpx_conv_if.conv port
);
  logic [7:0] s_exp;
  logic [10:0] d_exp;

  assign s_exp = port.bits[30:23];
  assign d_exp = port.bits[62:52];

  // Widen single or double to extended, keeping zero, denormal and infinity classes
  always_comb begin
    port.sign = 1'b0;
    port.exp = 15'h0000;
    port.mant = 64'h0;
    case (port.fmt)
      fpx_pkg::FMT_SINGLE: begin
        port.sign = port.bits[31];
        port.mant = {1'b1, port.bits[22:0], 40'h0};
        if (s_exp == 8'h00) begin
          port.mant = {1'b0, port.bits[22:0], 40'h0};
          port.exp = (port.bits[22:0] == 23'h0) ? 15'h0000 :
                     15'(fpx_pkg::SGL_DENORM_EXP + fpx_pkg::EXT_BIAS - fpx_pkg::SGL_BIAS);
        end else if (s_exp == 8'hFF) begin
          port.exp = fpx_pkg::EXT_EXP_MAX;
        end else begin
          port.exp = 15'({7'h00, s_exp} + fpx_pkg::EXT_BIAS - fpx_pkg::SGL_BIAS);
        end
      end
      fpx_pkg::FMT_DOUBLE: begin
        port.sign = port.bits[63];
        port.mant = {1'b1, port.bits[51:0], 11'h0};
        if (d_exp == 11'h000) begin
          port.mant = {1'b0, port.bits[51:0], 11'h0};
          port.exp = (port.bits[51:0] == 52'h0) ? 15'h0000 :
                     15'(fpx_pkg::DBL_DENORM_EXP + fpx_pkg::EXT_BIAS - fpx_pkg::DBL_BIAS);
        end else if (d_exp == 11'h7FF) begin
          port.exp = fpx_pkg::EXT_EXP_MAX;
        end else begin
          port.exp = 15'({4'h0, d_exp} + fpx_pkg::EXT_BIAS - fpx_pkg::DBL_BIAS);
        end
      end
      default: begin
        port.sign = port.bits[79];
        port.exp = port.bits[78:64];
        port.mant = port.bits[63:0];
      end
    endcase
  end
endmodule

// ### rtl/fpx_capture.sv
`timescale 1ns/1ns
module fpx_capture (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Exception request from the sequencer
  input wire logic EXC_VALID,
  output logic EXC_READY,
  input wire logic [1:0] EXC_KIND,
  input wire logic [3:0] EXC_OP,
  input wire logic [15:0] EXC_CMD_WORD,
  input wire logic [15:0] EXC_ENC_CMD,
  // Operands from the datapath
  input wire logic [1:0] EXC_SRC_FMT,
  input wire logic [79:0] EXC_SRC_OPND,
  input wire logic [2:0] EXC_SRC_TAG,
  input wire logic [1:0] EXC_DST_FMT,
  input wire logic [79:0] EXC_DST_OPND,
  // Intermediate result from the datapath
  input wire logic EXC_RES_SIGN,
  input wire logic [14:0] EXC_RES_EXP,
  input wire logic [66:0] EXC_RES_MANT,
  input wire logic [14:0] EXC_RND_EXP,
  input wire logic [63:0] EXC_RND_MANT,
  // AXI4-Lite write channels
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read channels
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Interrupt
  output logic IRQ
);

  // Frame contents
  logic [15:0] stage1_command_slot_reg;
  logic [15:0] stage3_encoded_command_slot_reg;
  logic [79:0] exception_source_temp_reg;
  logic [79:0] destination_temp_reg;
  logic writeback_sign_reg;
  logic [15:0] writeback_exp_reg;
  logic [63:0] writeback_mant_reg;
  logic writeback_guard_bit_reg;
  logic writeback_round_bit_reg;
  logic writeback_sticky_bit_reg;
  logic [2:0] source_tag_reg;
  logic stage1_valid_flag_reg;
  logic stage3_valid_flag_reg;
  logic tag_flag_reg;
  logic frame_lock_reg;

  // Next frame contents
  logic [15:0] stage1_command_slot_next;
  logic [15:0] stage3_encoded_command_slot_next;
  logic [79:0] exception_source_temp_next;
  logic [79:0] destination_temp_next;
  logic writeback_sign_next;
  logic [15:0] writeback_exp_next;
  logic [63:0] writeback_mant_next;
  logic writeback_guard_bit_next;
  logic writeback_round_bit_next;
  logic writeback_sticky_bit_next;
  logic [2:0] source_tag_next;
  logic stage1_valid_flag_next;
  logic stage3_valid_flag_next;
  logic tag_flag_next;

  // Control, status and bus state
  logic ctrl_en_reg;
  logic [fpx_pkg::ST_W-1:0] status_reg;
  logic [fpx_pkg::ST_W-1:0] status_next;
  logic [fpx_pkg::ST_W-1:0] mask_reg;
  logic [fpx_pkg::ST_W-1:0] events;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic rd_hit;
  logic wr_fire;
  logic wr_hit;
  logic capture;
  logic is_unary;
  logic is_arith;
  logic [31:0] ctrl_merged;
  logic [31:0] mask_merged;

  // Converted operands
  fpx_conv_if src_cv ();
  fpx_conv_if dst_cv ();

  // Pack sign, exponent and mantissa into one extended word
  function automatic logic [79:0] ext_pack(input logic s, input logic [14:0] e,
                                           input logic [63:0] m);
    ext_pack = {s, e, m};
  endfunction

  // Pick one bus word of an extended temp
  function automatic logic [31:0] temp_word(input logic [79:0] t, input logic [1:0] idx);
    case (idx)
      2'h0: temp_word = t[31:0];
      2'h1: temp_word = t[63:32];
      default: temp_word = {16'h0000, t[79:64]};
    endcase
  endfunction

  // Merge write data under byte strobes
  function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    strobe_merge = r;
  endfunction

  // Operand widening for the divide-by-zero frame
  assign src_cv.fmt = EXC_SRC_FMT;
  assign src_cv.bits = EXC_SRC_OPND;
  assign dst_cv.fmt = EXC_DST_FMT;
  assign dst_cv.bits = EXC_DST_OPND;

  fpx_convert u_src_conv (
    .port(src_cv.conv)
  );

  fpx_convert u_dst_conv (
    .port(dst_cv.conv)
  );

  // A new exception is taken only while enabled and the previous frame was released
  assign EXC_READY = ctrl_en_reg & ~frame_lock_reg;
  assign capture = EXC_VALID & EXC_READY;

  // Operation classes
  assign is_unary = (EXC_OP == fpx_pkg::OP_MOVE_REG) | (EXC_OP == fpx_pkg::OP_ABS) |
                    (EXC_OP == fpx_pkg::OP_NEG);
  assign is_arith = (EXC_OP == fpx_pkg::OP_ADD) | (EXC_OP == fpx_pkg::OP_SUB) |
                    (EXC_OP == fpx_pkg::OP_MUL) | (EXC_OP == fpx_pkg::OP_DIV) |
                    (EXC_OP == fpx_pkg::OP_SQRT);

  // Frame fill per exception case; cases not covered leave the frame flags clear
  always_comb begin
    stage1_command_slot_next = 16'h0000;
    stage3_encoded_command_slot_next = 16'h0000;
    exception_source_temp_next = 80'h0;
    destination_temp_next = 80'h0;
    writeback_sign_next = 1'b0;
    writeback_exp_next = 16'h0000;
    writeback_mant_next = 64'h0;
    writeback_guard_bit_next = 1'b0;
    writeback_round_bit_next = 1'b0;
    writeback_sticky_bit_next = 1'b0;
    source_tag_next = EXC_SRC_TAG;
    stage1_valid_flag_next = 1'b0;
    stage3_valid_flag_next = 1'b0;
    tag_flag_next = 1'b0;
    case (EXC_KIND)
      fpx_pkg::KIND_OVERFLOW_EXCEPTION: begin
        if (EXC_OP == fpx_pkg::OP_MOVE_MEM) begin
          stage1_command_slot_next = EXC_CMD_WORD;
          destination_temp_next = ext_pack(EXC_RES_SIGN, EXC_RND_EXP, EXC_RND_MANT);
          source_tag_next = fpx_pkg::TAG_NORM;
          stage1_valid_flag_next = 1'b1;
          tag_flag_next = 1'b1;
        end
      end
      fpx_pkg::KIND_UNDERFLOW_EXCEPTION: begin
        if (EXC_OP == fpx_pkg::OP_MOVE_MEM) begin
          stage1_command_slot_next = EXC_CMD_WORD;
          destination_temp_next = ext_pack(EXC_RES_SIGN, EXC_RES_EXP,
                                           EXC_RES_MANT[66:3]);
          source_tag_next = fpx_pkg::TAG_NORM;
          stage1_valid_flag_next = 1'b1;
          tag_flag_next = 1'b1;
        end else if (is_unary) begin
          stage1_command_slot_next = EXC_CMD_WORD;
          destination_temp_next = ext_pack(EXC_RES_SIGN, EXC_RES_EXP,
                                           EXC_RES_MANT[66:3]);
          source_tag_next = fpx_pkg::TAG_NORM;
          stage1_valid_flag_next = 1'b1;
          tag_flag_next = 1'b0;
        end else if (is_arith) begin
          stage3_encoded_command_slot_next = EXC_ENC_CMD;
          writeback_sign_next = EXC_RES_SIGN;
          writeback_exp_next = {1'b1, EXC_RES_EXP};
          writeback_mant_next = EXC_RES_MANT[66:3];
          writeback_guard_bit_next = EXC_RES_MANT[2];
          writeback_round_bit_next = EXC_RES_MANT[1];
          writeback_sticky_bit_next = EXC_RES_MANT[0];
          stage3_valid_flag_next = 1'b1;
          tag_flag_next = 1'b0;
        end
      end
      fpx_pkg::KIND_DZ: begin
        stage1_command_slot_next = EXC_CMD_WORD;
        exception_source_temp_next = ext_pack(src_cv.sign, src_cv.exp, src_cv.mant);
        source_tag_next = EXC_SRC_TAG;
        destination_temp_next = ext_pack(dst_cv.sign, dst_cv.exp, dst_cv.mant);
        stage1_valid_flag_next = 1'b1;
      end
      default: begin
        source_tag_next = EXC_SRC_TAG;
      end
    endcase
  end

  // Frame registers load on a taken exception
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      stage1_command_slot_reg <= 16'h0000;
      stage3_encoded_command_slot_reg <= 16'h0000;
      exception_source_temp_reg <= 80'h0;
      destination_temp_reg <= 80'h0;
      writeback_sign_reg <= 1'b0;
      writeback_exp_reg <= 16'h0000;
      writeback_mant_reg <= 64'h0;
      writeback_guard_bit_reg <= 1'b0;
      writeback_round_bit_reg <= 1'b0;
      writeback_sticky_bit_reg <= 1'b0;
      source_tag_reg <= 3'h0;
      stage1_valid_flag_reg <= 1'b0;
      stage3_valid_flag_reg <= 1'b0;
      tag_flag_reg <= 1'b0;
    end else if (capture) begin
      stage1_command_slot_reg <= stage1_command_slot_next;
      stage3_encoded_command_slot_reg <= stage3_encoded_command_slot_next;
      exception_source_temp_reg <= exception_source_temp_next;
      destination_temp_reg <= destination_temp_next;
      writeback_sign_reg <= writeback_sign_next;
      writeback_exp_reg <= writeback_exp_next;
      writeback_mant_reg <= writeback_mant_next;
      writeback_guard_bit_reg <= writeback_guard_bit_next;
      writeback_round_bit_reg <= writeback_round_bit_next;
      writeback_sticky_bit_reg <= writeback_sticky_bit_next;
      source_tag_reg <= source_tag_next;
      stage1_valid_flag_reg <= stage1_valid_flag_next;
      stage3_valid_flag_reg <= stage3_valid_flag_next;
      tag_flag_reg <= tag_flag_next;
    end
  end

  // Frame lock: set on capture, dropped by a release write
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      frame_lock_reg <= 1'b0;
    end else if (capture) begin
      frame_lock_reg <= 1'b1;
    end else if (wr_hit && awaddr_reg == fpx_pkg::REG_RELEASE && wstrb_reg[0] &&
                 wdata_reg[0]) begin
      frame_lock_reg <= 1'b0;
    end
  end

  // Events per exception kind
  always_comb begin
    events = '0;
    if (capture) begin
      events[fpx_pkg::ST_OVERFLOW_EXCEPTION] = (EXC_KIND == fpx_pkg::KIND_OVERFLOW_EXCEPTION);
      events[fpx_pkg::ST_UNDERFLOW_EXCEPTION] = (EXC_KIND == fpx_pkg::KIND_UNDERFLOW_EXCEPTION);
      events[fpx_pkg::ST_DZ] = (EXC_KIND == fpx_pkg::KIND_DZ);
    end
  end

  // Sticky status, write one to clear, a new event wins over the clear
  always_comb begin
    status_next = status_reg;
    if (wr_hit && awaddr_reg == fpx_pkg::REG_STATUS && wstrb_reg[0]) begin
      status_next = status_reg & ~wdata_reg[fpx_pkg::ST_W-1:0];
    end
    status_next = status_next | events;
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  // Control and mask words after the byte-strobe merge
  assign ctrl_merged = strobe_merge({31'h0, ctrl_en_reg}, wdata_reg, wstrb_reg);
  assign mask_merged = strobe_merge({29'h0, mask_reg}, wdata_reg, wstrb_reg);

  // Control and mask registers
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_en_reg <= fpx_pkg::CTRL_EN_RST;
      mask_reg <= '0;
    end else if (wr_hit) begin
      if (awaddr_reg == fpx_pkg::REG_CTRL) begin
        ctrl_en_reg <= ctrl_merged[fpx_pkg::CTRL_EN];
      end
      if (awaddr_reg == fpx_pkg::REG_MASK) begin
        mask_reg <= mask_merged[fpx_pkg::ST_W-1:0];
      end
    end
  end

  // Level interrupt from unmasked status
  assign IRQ = |(status_reg & mask_reg);

  // Write address and data are latched in either order
  assign S_AXI_AWREADY = ~aw_held_reg & ~bvalid_reg;
  assign S_AXI_WREADY = ~w_held_reg & ~bvalid_reg;
  assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_hit = wr_fire & ((awaddr_reg == fpx_pkg::REG_CTRL) |
                             (awaddr_reg == fpx_pkg::REG_RELEASE) |
                             (awaddr_reg == fpx_pkg::REG_STATUS) |
                             (awaddr_reg == fpx_pkg::REG_MASK));

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= {S_AXI_AWADDR[7:2], 2'h0};
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_reg <= 1'b1;
      wdata_reg <= S_AXI_WDATA;
      wstrb_reg <= S_AXI_WSTRB;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // Write response, error for an unmapped or read-only offset
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= fpx_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? fpx_pkg::RESP_OKAY : fpx_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;

  // Read decode of frame, status and control
  always_comb begin
    rdata_next = 32'h0;
    rd_hit = 1'b1;
    case ({S_AXI_ARADDR[7:2], 2'h0})
      fpx_pkg::REG_CTRL: rdata_next[fpx_pkg::CTRL_EN] = ctrl_en_reg;
      fpx_pkg::REG_RELEASE: rdata_next = 32'h0;
      fpx_pkg::REG_STATUS: rdata_next[fpx_pkg::ST_W-1:0] = status_reg;
      fpx_pkg::REG_MASK: rdata_next[fpx_pkg::ST_W-1:0] = mask_reg;
      fpx_pkg::REG_INFO: begin
        rdata_next[fpx_pkg::INFO_E1] = stage1_valid_flag_reg;
        rdata_next[fpx_pkg::INFO_E3] = stage3_valid_flag_reg;
        rdata_next[fpx_pkg::INFO_T] = tag_flag_reg;
        rdata_next[fpx_pkg::INFO_TAG +: 3] = source_tag_reg;
        rdata_next[fpx_pkg::INFO_STICKY] = writeback_sticky_bit_reg;
        rdata_next[fpx_pkg::INFO_ROUND] = writeback_round_bit_reg;
        rdata_next[fpx_pkg::INFO_GUARD] = writeback_guard_bit_reg;
        rdata_next[fpx_pkg::INFO_LOCK] = frame_lock_reg;
      end
      fpx_pkg::REG_CMD: begin
        rdata_next[15:0] = stage1_command_slot_reg;
        rdata_next[fpx_pkg::CMD3_POS +: 16] = stage3_encoded_command_slot_reg;
      end
      fpx_pkg::REG_SRC_LO: rdata_next = temp_word(exception_source_temp_reg, 2'h0);
      fpx_pkg::REG_SRC_HI: rdata_next = temp_word(exception_source_temp_reg, 2'h1);
      fpx_pkg::REG_SRC_SE: rdata_next = temp_word(exception_source_temp_reg, 2'h2);
      fpx_pkg::REG_DST_LO: rdata_next = temp_word(destination_temp_reg, 2'h0);
      fpx_pkg::REG_DST_HI: rdata_next = temp_word(destination_temp_reg, 2'h1);
      fpx_pkg::REG_DST_SE: rdata_next = temp_word(destination_temp_reg, 2'h2);
      fpx_pkg::REG_WB_LO: rdata_next = writeback_mant_reg[31:0];
      fpx_pkg::REG_WB_HI: rdata_next = writeback_mant_reg[63:32];
      fpx_pkg::REG_WB_SE: rdata_next = {15'h0000, writeback_sign_reg, writeback_exp_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel, one read at a time
  assign S_AXI_ARREADY = ~rvalid_reg;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= fpx_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rdata_next;
      rresp_reg <= rd_hit ? fpx_pkg::RESP_OKAY : fpx_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

endmodule

// ### tb/fpx_monitor.sv
`timescale 1ns/1ns
module fpx_monitor (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // Exception handshake
  input wire logic EXC_VALID,
  input wire logic EXC_READY,
  // Bus handshakes
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  // Transfer events
  sequence s_cap; EXC_VALID && EXC_READY; endsequence
  sequence s_wr; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY; endsequence
  sequence s_rd; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
  // A capture locks the frame; bus answers on time and holds
  a_frame_lock:
    assert property (s_cap |=> !EXC_READY) else $error("ready after capture");
  a_write_answer:
    assert property (s_wr |=> !S_AXI_BVALID ##1 S_AXI_BVALID) else $error("write answer late");
  a_bresp_hold:
    assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("bvalid dropped");
  a_write_block:
    assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("write open");
  a_read_answer:
    assert property (s_rd |=> S_AXI_RVALID) else $error("read answer late");
  a_rdata_hold:
    assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data moved");
  a_read_block:
    assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("read open");
  a_read_done:
    assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID) else $error("rvalid stuck");
endmodule
bind fpx_capture fpx_monitor u_fpx_monitor (.*);

// ### tb/fpx_seq_model.sv
`timescale 1ns/1ns
module fpx_seq_model (
  // Clock
  input wire logic clk,
  // Exception offer
  output logic valid,
  input wire logic ready,
  output logic [1:0] kind,
  output logic [3:0] op
);
  // Idle until asked
  initial {valid, kind, op} = 7'h0;
  // Offer and hold until taken; ok stays low on timeout
  task automatic offer(input logic [1:0] k, input logic [3:0] o, output bit ok);
    @(posedge clk);
    {valid, kind, op} <= {1'b1, k, o};
    ok = 1'b0;
    repeat (60) if (!ok) begin
      @(negedge clk);
      ok = ready;
    end
    @(posedge clk);
    {valid, kind} <= {1'b0, ~k};
  endtask
endmodule

// ### tb/fpx_capture_tb_top.sv
`timescale 1ns/1ns
module fpx_capture_tb_top;
  // Design ports and bench state
  logic REF_CLK, RESET_N, EXC_VALID, EXC_READY, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
  logic S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic S_AXI_RREADY, IRQ, EXC_RES_SIGN = 1'b1;
  logic [1:0] EXC_KIND, S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic [1:0] EXC_SRC_FMT = fpx_pkg::FMT_SINGLE, EXC_DST_FMT = fpx_pkg::FMT_DOUBLE;
  logic [2:0] EXC_SRC_TAG = 3'h5;
  logic [3:0] EXC_OP, S_AXI_WSTRB = 4'hF;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [14:0] EXC_RES_EXP = 15'h0123, EXC_RND_EXP = 15'h0456;
  logic [15:0] EXC_CMD_WORD = 16'hA5C3, EXC_ENC_CMD = 16'h3C5A;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rdv;
  logic [63:0] EXC_RND_MANT = 64'hFEDC_BA98_7654_3210;
  logic [66:0] EXC_RES_MANT = 67'h6_2468_ACE0_1357_9BDD;
  logic [79:0] EXC_SRC_OPND = 80'h3F80_0000, EXC_DST_OPND = 80'h4000_0000_0000_0000;
  int errors, comparisons, n;
  bit ok;
  // Block and sequencer model
  fpx_capture u_fpx_capture (.*);
  fpx_seq_model u_fpx_seq_model (.clk(REF_CLK), .valid(EXC_VALID), .ready(EXC_READY),
    .kind(EXC_KIND), .op(EXC_OP));
  // Verdict
  task automatic finish_test();
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Compare and count
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // Bounded wait ran out
  task automatic hang();
    errors++;
    $display("[FAIL] %0t timeout", $time);
    finish_test();
  endtask
  // One bus write or read; rsp and rdv hold the answer
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    if (w) {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= {a, d, 3'h7};
    else {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'h3};
    for (n = 0; n < 60; n++) begin
      @(negedge REF_CLK);
      if (w ? S_AXI_AWREADY && S_AXI_WREADY : S_AXI_ARREADY) break;
    end
    if (n == 60) hang();
    @(posedge REF_CLK);
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} <= 3'h0;
    for (n = 0; n < 60; n++) begin
      @(negedge REF_CLK);
      if (w ? S_AXI_BVALID : S_AXI_RVALID) break;
    end
    if (n == 60) hang();
    {rsp, rdv} = w ? {S_AXI_BRESP, 32'h0} : {S_AXI_RRESP, S_AXI_RDATA};
    @(posedge REF_CLK);
    {S_AXI_BREADY, S_AXI_RREADY} <= 2'h0;
  endtask
  // Register and extended-value checks
  task automatic ck(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rdv, e);
  endtask
  task automatic ck3(input logic [7:0] b, input logic [31:0] se, input logic [63:0] m);
    ck(b, m[31:0]);
    ck(b + 8'h4, m[63:32]);
    ck(b + 8'h8, se);
  endtask
  // Free the frame, then offer one exception
  task automatic cap(input logic [1:0] k, input logic [3:0] o);
    bus(1'b1, 8'h04, 32'h1);
    u_fpx_seq_model.offer(k, o, ok);
    if (!ok) hang();
  endtask
  // Overflow on a move to memory keeps the rounded result
  task automatic t_overflow_exception();
    cap(fpx_pkg::KIND_OVERFLOW_EXCEPTION, fpx_pkg::OP_MOVE_MEM);
    ck(8'h14, {16'h0, EXC_CMD_WORD});
    ck3(8'h30, {16'h0, EXC_RES_SIGN, EXC_RND_EXP}, EXC_RND_MANT);
    ck(8'h10, 32'h0001_0005);
  endtask
  // Underflow of moves, absolute value and negate keeps the unrounded result
  task automatic t_underflow_exception_move();
    for (int o = 0; o < 4; o++) begin
      cap(fpx_pkg::KIND_UNDERFLOW_EXCEPTION, 4'(o));
      ck(8'h14, {16'h0, EXC_CMD_WORD});
      ck3(8'h30, {16'h0, EXC_RES_SIGN, EXC_RES_EXP}, EXC_RES_MANT[66:3]);
      ck(8'h10, (o == 1) ? 32'h0001_0005 : 32'h0001_0001);
    end
  endtask
  // Arithmetic underflow fills the write-back slots; tag flag ignored
  task automatic t_underflow_exception_arith();
    for (int o = 4; o < 9; o++) begin
      cap(fpx_pkg::KIND_UNDERFLOW_EXCEPTION, 4'(o));
      ck(8'h14, {EXC_ENC_CMD, 16'h0});
      ck3(8'h40, {15'h0, EXC_RES_SIGN, 1'b1, EXC_RES_EXP}, EXC_RES_MANT[66:3]);
      bus(1'b0, 8'h10, 32'h0);
      cmp(rdv & 32'hFFFF_FFFB,
        {15'h0, 1'b1, 5'h0, EXC_RES_MANT[2:0], 1'b0, EXC_SRC_TAG, 4'h2});
    end
  endtask
  // Divide by zero widens single 1.0 and double 2.0 to extended
  task automatic t_div_zero();
    cap(fpx_pkg::KIND_DZ, fpx_pkg::OP_DIV);
    ck3(8'h20, 32'h0000_3FFF, 64'h8000_0000_0000_0000);
    ck(8'h10, 32'h0001_0051);
    ck3(8'h30, 32'h0000_4000, 64'h8000_0000_0000_0000);
  endtask
  // Interrupt mask and clear, refused bus accesses
  task automatic t_irq_bus();
    bus(1'b1, 8'h08, 32'h7);
    cap(fpx_pkg::KIND_OVERFLOW_EXCEPTION, fpx_pkg::OP_ADD);
    ck(8'h08, 32'h1);
    ck(8'h10, 32'h0001_0050);
    cmp({31'h0, IRQ}, 32'h0);
    bus(1'b1, 8'h0C, 32'h1);
    @(negedge REF_CLK);
    cmp({31'h0, IRQ}, 32'h1);
    bus(1'b1, 8'h08, 32'h1);
    @(negedge REF_CLK);
    cmp({31'h0, IRQ}, 32'h0);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b1, 8'h04, 32'h1);
    @(negedge REF_CLK);
    cmp({31'h0, EXC_READY}, 32'h0);
    ck(8'h00, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    @(negedge REF_CLK);
    cmp({31'h0, EXC_READY}, 32'h1);
    bus(1'b1, 8'h10, 32'h0);
    cmp({30'h0, rsp}, {30'h0, fpx_pkg::RESP_SLVERR});
    bus(1'b0, 8'hFC, 32'h0);
    cmp({rsp, rdv[29:0]}, {fpx_pkg::RESP_SLVERR, 30'h0});
  endtask
  // Clock
  initial begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end
  // Reset, then the scenarios
  initial begin
    {RESET_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 6'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
    repeat (12) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    t_overflow_exception();
    t_underflow_exception_move();
    t_underflow_exception_arith();
    t_div_zero();
    t_irq_bus();
    finish_test();
  end
endmodule
